// >>> rtl/lac_autorange.v
// Purpose: Range selection and result formatting for a light sensor
// Assumes: Front end supplies a count and overflow flag per conversion
// Notes: No register bus; fields are plain ports
// Notes on behaviour
// - Scale code 12 runs automatic range selection
// - Auto range follows present light and previous result
// - Low result lowers range by one or two steps
// - High result raises range by exactly one step
// - Overflow in auto mode below top range aborts, result not published
// - After abort below top range, step up and restart
// - Retries may stretch a result beyond the period
// - Manual scale disables auto logic, measures at that range
// - Codes 0 to 8 select nine doubling ranges
// - Period codes 0 to 11 map to 0.6 to 800 ms
// - Period spans start through result update
// - Result is 4-bit scale index and 20-bit count
// - Index equals range used; count linear within it
// - Upper 12 count bits and lower 8 in separate fields
// - Linearised value is count shifted by index, 28 bits
`default_nettype none
`include "lac_defines.vh"
module lac_autorange #(
	parameter DIV = 1
)
(
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire [3:0] i_scale_sel,
	input wire [3:0] i_period_sel,
	input wire i_run,
	input wire i_fe_valid,
	input wire [19:0] i_fe_count,
	input wire i_fe_overflow,
	output reg o_fe_start,
	output reg [3:0] o_fe_range,
	output reg [3:0] o_scale_index,
	output reg [11:0] o_count_upper,
	output reg [7:0] o_count_lower,
	output reg [27:0] o_linear,
	output reg o_result_valid,
	output reg o_busy
);
	localparam S_IDLE = 2'b00;
	localparam S_MEAS = 2'b01;
	localparam S_WAIT = 2'b10;

	reg [1:0] state_q;
	reg [3:0] range_q;
	reg [19:0] cnt_q;
	reg have_q;
	wire tstart;
	wire retry;
	wire t_busy;
	wire t_done;
	wire auto_mode;

	assign auto_mode = (i_scale_sel == `LAC_SCALE_AUTO);
	assign retry = i_fe_valid && i_fe_overflow && auto_mode &&
		(o_fe_range < `LAC_SCALE_MAX);
	// Timer loads on the same edge as the front end start, so the
	// period counts from initiation, not one cycle late
	assign tstart = ((state_q == S_IDLE) && i_run) ||
		((state_q == S_MEAS) && retry);

	lac_period_timer #(.DIV(DIV)) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_start(tstart),
		.i_period(i_period_sel),
		.o_busy(t_busy),
		.o_done(t_done)
	);

	// Next range from previous result
	function [3:0] next_range;
		input [3:0] r;
		input [19:0] c;
		begin
			next_range = r;
			if (c < `LAC_LOW_TWO && r > 4'h1)
				next_range = r - 4'h2;
			else if (c < `LAC_LOW_ONE && r > 4'h0)
				next_range = r - 4'h1;
			else if (c >= `LAC_HIGH_ONE && r < `LAC_SCALE_MAX)
				next_range = r + 4'h1;
		end
	endfunction

	function [27:0] linearise;
		input [19:0] c;
		input [3:0] e;
		begin
			linearise = {8'h00, c} << e;
		end
	endfunction

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			state_q <= S_IDLE;
			range_q <= 4'h0;
			cnt_q <= 20'h0;
			have_q <= 1'b0;
			o_fe_start <= 1'b0;
			o_fe_range <= 4'h0;
			o_scale_index <= 4'h0;
			o_count_upper <= 12'h0;
			o_count_lower <= 8'h0;
			o_linear <= 28'h0;
			o_result_valid <= 1'b0;
			o_busy <= 1'b0;
		end
		else
		begin
			o_fe_start <= 1'b0;
			o_result_valid <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					o_busy <= 1'b0;
					if (i_run)
					begin
						if (auto_mode)
						begin
							if (have_q)
								o_fe_range <= next_range(range_q, cnt_q);
							else
								o_fe_range <= `LAC_SCALE_MAX;
						end
						else
						begin
							o_fe_range <= i_scale_sel;
							have_q <= 1'b0;
						end
						o_fe_start <= 1'b1;
						o_busy <= 1'b1;
						state_q <= S_MEAS;
					end
				end
				S_MEAS:
				begin
					if (i_fe_valid)
					begin
						if (retry)
						begin
							o_fe_range <= o_fe_range + 4'h1;
							o_fe_start <= 1'b1;
						end
						else
						begin
							range_q <= o_fe_range;
							cnt_q <= i_fe_count;
							have_q <= auto_mode;
							state_q <= S_WAIT;
						end
					end
				end
				S_WAIT:
				begin
					// Publish at period end so period covers update
					if (!t_busy || t_done)
					begin
						o_scale_index <= range_q;
						o_count_upper <= cnt_q[19:8];
						o_count_lower <= cnt_q[7:0];
						o_linear <= linearise(cnt_q, range_q);
						o_result_valid <= 1'b1;
						o_busy <= 1'b0;
						state_q <= S_IDLE;
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> rtl/lac_defines.vh
// Purpose: Shared constants for the light autorange conversion block
// Assumes: 25 MHz system clock
// Notes: Times in microseconds; cycle counts derived from clock rate
`ifndef LAC_DEFINES_VH
`define LAC_DEFINES_VH
`define LAC_CLK_MHZ 25
`define LAC_SCALE_AUTO 4'hc
`define LAC_SCALE_MAX 4'h8
`define LAC_PERIOD_MAX 4'hb
`define LAC_CNT_W 20
`define LAC_MSB_W 12
`define LAC_LSB_W 8
`define LAC_LIN_W 28
`define LAC_SCALE_RST 4'hc
`define LAC_PERIOD_RST 4'h8
// Thresholds as fractions of full scale on the top count bits
`define LAC_LOW_TWO 20'h04000
`define LAC_LOW_ONE 20'h20000
`define LAC_HIGH_ONE 20'hc0000
`define LAC_T0_US 600
`define LAC_T1_US 1000
`define LAC_T2_US 1800
`define LAC_T3_US 3400
`define LAC_T4_US 6500
`define LAC_T5_US 12700
`define LAC_T6_US 25000
`define LAC_T7_US 50000
`define LAC_T8_US 100000
`define LAC_T9_US 200000
`define LAC_T10_US 400000
`define LAC_T11_US 800000
`endif

// >>> rtl/lac_period_timer.v
// Purpose: Conversion period timer for one measurement
// Assumes: Start pulse from the sequencer, same clock
// Notes: Period code is latched at start so changes apply next time
`default_nettype none
`include "lac_defines.vh"
module lac_period_timer #(
	parameter DIV = 1
)
(
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_start,
	input wire [3:0] i_period,
	output wire o_busy,
	output wire o_done
);
	reg [31:0] cnt_q;
	reg busy_q;

	// Cycle count for each period code; DIV lets a bench shrink the period
	function [31:0] period_cycles;
		input [3:0] code;
		reg [31:0] us;
		begin
			case (code)
				4'h0: us = `LAC_T0_US;
				4'h1: us = `LAC_T1_US;
				4'h2: us = `LAC_T2_US;
				4'h3: us = `LAC_T3_US;
				4'h4: us = `LAC_T4_US;
				4'h5: us = `LAC_T5_US;
				4'h6: us = `LAC_T6_US;
				4'h7: us = `LAC_T7_US;
				4'h8: us = `LAC_T8_US;
				4'h9: us = `LAC_T9_US;
				4'ha: us = `LAC_T10_US;
				default: us = `LAC_T11_US;
			endcase
			period_cycles = (us * `LAC_CLK_MHZ) / DIV;
			if (period_cycles == 32'h0)
				period_cycles = 32'h1;
		end
	endfunction

	assign o_busy = busy_q;
	assign o_done = busy_q && (cnt_q == 32'h1);

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
		end
		else if (i_start)
		begin
			cnt_q <= period_cycles(i_period);
			busy_q <= 1'b1;
		end
		else if (busy_q)
		begin
			cnt_q <= cnt_q - 32'h1;
			if (cnt_q == 32'h1)
				busy_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> verif/lac_autorange_asserts.sv
// Purpose: Port checks for lac_autorange
// Assumes: One clock, sync reset
// Notes: Ports grouped per line to save space
`default_nettype none
module lac_asserts(
	input wire logic i_sys_clk, i_rst_n, i_fe_valid, i_fe_overflow,
	input wire logic o_fe_start, o_result_valid, o_busy,
	input wire logic [3:0] i_scale_sel, o_fe_range, o_scale_index,
	input wire logic [11:0] o_count_upper,
	input wire logic [7:0] o_count_lower,
	input wire logic [27:0] o_linear
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	wire ovr = i_fe_valid && i_fe_overflow && i_scale_sel == 4'hc &&
		o_fe_range < 4'h8;
	lin_val_a: assert property (o_result_valid |-> o_linear ==
		{8'h0, o_count_upper, o_count_lower} << o_scale_index)
		else $error("bad linear");
	idx_used_a: assert property (o_result_valid |->
		o_scale_index == o_fe_range) else $error("bad index");
	man_rng_a: assert property (o_fe_start && i_scale_sel < 4'h9 |->
		o_fe_range == i_scale_sel) else $error("bad range");
	retry_up_a: assert property (ovr |=> o_fe_start &&
		o_fe_range == $past(o_fe_range) + 4'h1) else $error("no retry");
	abort_hide_a: assert property (ovr |=>
		(!o_result_valid)[*8]) else $error("aborted result");
	valid_pulse_a: assert property (o_result_valid |=>
		!o_result_valid) else $error("long valid");
	busy_hold_a: assert property (o_fe_start |=>
		o_busy[*8]) else $error("busy dropped");
	busy_done_a: assert property (o_result_valid |->
		!o_busy) else $error("busy at publish");
endmodule
bind lac_autorange lac_asserts u_asr(.*);
`default_nettype wire

// >>> verif/lac_fe_model.sv
// Purpose: Front end stand-in
// Assumes: Light given as a linear count
// Notes: Latency 2 to 11 cycles after start, below any period
`default_nettype none
module lac_fe_model(
	input wire logic i_clk,
	input wire logic i_start,
	input wire logic [3:0] i_rng,
	input wire logic [27:0] i_lux,
	output var logic o_vld = 1'b0,
	output var logic [19:0] o_cnt = 20'h0,
	output var logic o_ovf = 1'b0
);
	int n = -1;
	wire [27:0] s = i_lux >> i_rng;
	always @(posedge i_clk)
	begin
		o_vld <= 1'b0;
		o_cnt <= ~o_cnt; // Stale count scrambled, never held
		n <= i_start ? $urandom_range(10, 1) : n - (n >= 0);
		if (n == 0)
		begin
			o_vld <= 1'b1;
			o_ovf <= s > 28'hfffff;
			o_cnt <= s > 28'hfffff ? 20'hfffff : s[19:0];
		end
	end
endmodule
`default_nettype wire

// >>> verif/lac_autorange_tb.sv
// Purpose: Bench for lac_autorange
// Assumes: DIV of 1000 shortens periods
// Notes: Expected auto range kept in er
`default_nettype none
module lac_autorange_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 0, i_rst_n = 0, i_run = 0;
	logic i_fe_valid, i_fe_overflow, o_fe_start, o_result_valid, o_busy;
	logic [3:0] i_scale_sel = 4'hc, i_period_sel = 4'h0, o_fe_range;
	logic [3:0] o_scale_index, er = 4'h8;
	logic [19:0] i_fe_count;
	logic [11:0] o_count_upper;
	logic [7:0] o_count_lower;
	logic [27:0] o_linear, lux = 28'h0;
	int miscompares = 0, checked = 0, cyc = 0;
	int us[12] = '{600, 1000, 1800, 3400, 6500, 12700, 25000,
		50000, 100000, 200000, 400000, 800000};
	always #20 i_sys_clk = ~i_sys_clk;
	lac_autorange #(.DIV(1000)) DUT(.*);
	lac_fe_model FE(.i_clk(i_sys_clk), .i_start(o_fe_start),
		.i_rng(o_fe_range), .i_lux(lux), .o_vld(i_fe_valid),
		.o_cnt(i_fe_count), .o_ovf(i_fe_overflow));
	task end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic ck(input logic [27:0] g, e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %0t %h %h", $time, g, e);
		end
	endtask
	task automatic ms(input logic [3:0] sc, pc, input logic [27:0] l);
		logic [3:0] r;
		logic [19:0] c;
		int t;
		r = sc == 4'hc ? er : sc;
		while (sc == 4'hc && r < 4'h8 && l >> r > 28'hfffff)
			r++;
		c = l >> r > 28'hfffff ? 20'hfffff : 20'(l >> r);
		i_scale_sel <= sc;
		i_period_sel <= pc;
		lux <= l;
		i_run <= 1'b1;
		@(posedge i_sys_clk);
		i_run <= 1'b0;
		t = 0;
		while (o_result_valid !== 1'b1 && ++cyc < 90000)
		begin
			@(posedge i_sys_clk);
			t = o_fe_start ? 0 : t + 1; // Period counts from last start
		end
		if (cyc >= 90000)
		begin
			miscompares++;
			end_sim();
		end
		ck(28'(o_scale_index), 28'(r));
		ck(28'({o_count_upper, o_count_lower}), 28'(c));
		ck(o_linear, 28'(c) << r);
		ck(28'(t), 28'(us[pc] * 25 / 1000));
		if (sc == 4'hc)
			er = c < 20'h04000 ? (r > 1 ? r - 4'h2 : 4'h0) :
				c < 20'h20000 ? r - 4'(r > 0) :
				c >= 20'hc0000 && r < 4'h8 ? r + 4'h1 : r;
	endtask
	initial
	begin
		void'($urandom(63));
		repeat (12) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		repeat (4) ms(4'hc, 4'h0, 28'h100);
		ms(4'hc, 4'h1, 28'hfffffff);
		repeat (12)
			ms(4'hc, 4'($urandom_range(2)), 28'($urandom >> $urandom_range(31)));
		for (int s = 0; s < 9; s++)
			ms(4'(s), 4'h0, 28'($urandom));
		for (int p = 0; p < 12; p++)
			ms(4'h5, 4'(p), 28'($urandom >> 8));
		end_sim();
	end
endmodule
`default_nettype wire
